/* hw/ors_defines.vh */
/*
 Constants for the output ramp sequencer: register offsets, field
 positions, reset values and timing counts.
 Assumes a 50 MHz clock and a master step clock from the power manager.
*/
`ifndef ORS_DEFINES_VH
`define ORS_DEFINES_VH
`define ORS_ADDR_TON 8'h05
`define ORS_ADDR_TOFF 8'h06
`define ORS_ADDR_RAMP 8'h03
`define ORS_ADDR_DROOP 8'h07
`define ORS_TON_RST 8'h00
`define ORS_TOFF_RST 8'h00
`define ORS_RAMP_RST 8'h1C
`define ORS_DROOP_RST 8'h00
`define ORS_RISE_HI 6
`define ORS_RISE_LO 4
`define ORS_FALL_EN_BIT 3
`define ORS_FALL_HI 2
`define ORS_FALL_LO 0
`define ORS_RATE_RESERVED 3'h7
`define ORS_STEP_MV 10
`define ORS_LSB_MV_X10 25
`define ORS_STEP_LSB 12'h004
`define ORS_MS_US 1000
`define ORS_TICK_US 10
`define ORS_TICKS_PER_MS (`ORS_MS_US / `ORS_TICK_US)
`define ORS_MS_TICKS 10'h064
`endif

/* hw/ors_sequencer.v */
/*
 Output ramp sequencer top: registers written over a simple byte port
 from the single-wire bus decoder, turn-on/off delays, stepped ramps.
 Assumes the master clock arrives as a pin and is synchronised here;
 each of its rising edges is a 10 us tick. Voltages are 12-bit codes of
 2.5 mV per LSB; 10 mV is four LSB.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ors_defines.vh"
module ors_sequencer (
    input wire clock,
    input wire rst,
    input wire master_clk_pin,
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    input wire turn_on,
    input wire [11:0] setpoint,
    input wire [11:0] prebias_level,
    input wire [11:0] load_current,
    output reg [11:0] vref_ff,
    output reg switches_on_ff,
    output reg ramping_ff,
    output reg steady_ff
);
    localparam S_OFF = 6'b000001;
    localparam S_ONDLY = 6'b000010;
    localparam S_RISE = 6'b000100;
    localparam S_ON = 6'b001000;
    localparam S_OFFDLY = 6'b010000;
    localparam S_FALL = 6'b100000;

    // Ticks of 10 us per 10 mV step for each rate code; zero is invalid for rising only
    function [7:0] step_ticks;
        input [2:0] code;
        input rising;
        begin
            case (code)
                3'h0: step_ticks = rising ? 8'h00 : 8'h14;
                3'h1: step_ticks = 8'h0A;
                3'h2: step_ticks = 8'h05;
                3'h3: step_ticks = 8'h04;
                3'h4: step_ticks = 8'h02;
                3'h5: step_ticks = 8'h01;
                3'h6: step_ticks = 8'h01;
                default: step_ticks = 8'h00;
            endcase
        end
    endfunction

    reg [7:0] ton_ff, toff_ff, droop_ff;
    reg [2:0] rise_code_ff, fall_code_ff;
    reg fall_en_ff;
    reg [5:0] state_ff, nxt_state;
    reg [2:0] msync_ff;
    reg [6:0] tick_cnt_ff;
    reg [7:0] ms_cnt_ff;
    reg [17:0] off_ticks_ff;
    reg [17:0] fall_ticks_ff;
    reg ms_tick;
    wire tick;
    wire step;
    wire [11:0] droop_adj;
    wire [11:0] target;
    wire [2:0] wr_rise, wr_fall;
    wire [17:0] off_limit;

    // Turn-off interval in master ticks
    assign off_limit = {10'h000, toff_ff} * {8'h00, `ORS_MS_TICKS};

    assign tick = msync_ff[1] & ~msync_ff[2];
    assign wr_rise = reg_wdata[`ORS_RISE_HI:`ORS_RISE_LO];
    assign wr_fall = reg_wdata[`ORS_FALL_HI:`ORS_FALL_LO];
    // Droop: code times current/8 LSB, a coarse proportional offset
    assign droop_adj = (load_current >> 3) * {9'h000, droop_ff[2:0]};
    assign target = (setpoint > droop_adj) ? setpoint - droop_adj : 12'h000;

    // Second stage only reads the first; edge detect uses later stages
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            msync_ff <= 3'b000;
        end else begin
            msync_ff <= {msync_ff[1:0], master_clk_pin};
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ton_ff <= `ORS_TON_RST;
            toff_ff <= `ORS_TOFF_RST;
            droop_ff <= `ORS_DROOP_RST;
            rise_code_ff <= 3'h1;
            fall_en_ff <= 1'b1;
            fall_code_ff <= 3'h4;
        end else if (reg_wr) begin
            case (reg_addr)
                `ORS_ADDR_TON: ton_ff <= reg_wdata;
                `ORS_ADDR_TOFF: toff_ff <= reg_wdata;
                `ORS_ADDR_DROOP: droop_ff <= {5'h00, reg_wdata[2:0]};
                `ORS_ADDR_RAMP: begin
                    if (wr_rise != `ORS_RATE_RESERVED &&
                        wr_rise != 3'h0) begin
                        rise_code_ff <= wr_rise;
                    end
                    if (wr_fall != `ORS_RATE_RESERVED) begin
                        fall_code_ff <= wr_fall;
                    end
                    fall_en_ff <= reg_wdata[`ORS_FALL_EN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
        end else begin
            case (reg_addr)
                `ORS_ADDR_TON: reg_rdata_ff <= ton_ff;
                `ORS_ADDR_TOFF: reg_rdata_ff <= toff_ff;
                `ORS_ADDR_DROOP: reg_rdata_ff <= droop_ff;
                `ORS_ADDR_RAMP: reg_rdata_ff <= {1'b0, rise_code_ff,
                    fall_en_ff, fall_code_ff};
                default: reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    // Millisecond enable derived from the master clock ticks
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt_ff <= 7'h00;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= 1'b0;
            // Restarted per command, so the first millisecond is never short
            if (state_ff != S_ONDLY) begin
                tick_cnt_ff <= 7'h00;
            end else if (tick) begin
                if (tick_cnt_ff == `ORS_TICKS_PER_MS - 1) begin
                    tick_cnt_ff <= 7'h00;
                    ms_tick <= 1'b1;
                end else begin
                    tick_cnt_ff <= tick_cnt_ff + 7'h01;
                end
            end
        end
    end

    ors_step_timer u_step (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .run(ramping_ff),
        .ticks_per_step(state_ff == S_FALL ?
            step_ticks(fall_code_ff, 1'b0) :
            step_ticks(rise_code_ff, 1'b1)),
        .step_ff(step)
    );

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_OFF: if (turn_on) nxt_state = S_ONDLY;
            S_ONDLY: begin
                if (!turn_on) begin
                    nxt_state = S_OFF;
                end else if (ms_cnt_ff >= ton_ff) begin
                    nxt_state = S_RISE;
                end
            end
            S_RISE: begin
                if (!turn_on) begin
                    nxt_state = S_OFFDLY;
                end else if (vref_ff >= target) begin
                    nxt_state = S_ON;
                end
            end
            S_ON: if (!turn_on) nxt_state = S_OFFDLY;
            S_OFFDLY: begin
                if (turn_on) begin
                    nxt_state = S_ONDLY;
                end else if (fall_en_ff) begin
                    // Remaining interval no longer than the whole ramp; start now
                    if (off_ticks_ff + fall_ticks_ff >= off_limit) begin
                        nxt_state = S_FALL;
                    end
                end else if (off_ticks_ff >= off_limit) begin
                    nxt_state = S_OFF;
                end
            end
            S_FALL: begin
                if (turn_on) begin
                    nxt_state = S_RISE;
                end else if (vref_ff == 12'h000) begin
                    nxt_state = S_OFF;
                end
            end
            default: nxt_state = S_OFF;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= S_OFF;
            ms_cnt_ff <= 8'h00;
            off_ticks_ff <= 18'h00000;
            fall_ticks_ff <= 18'h00000;
            vref_ff <= 12'h000;
            switches_on_ff <= 1'b0;
            ramping_ff <= 1'b0;
            steady_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ms_cnt_ff <= (state_ff == S_ONDLY) ?
                (ms_tick && ms_cnt_ff != 8'hFF ? ms_cnt_ff + 8'h01 :
                ms_cnt_ff) : 8'h00;
            // Interval is counted from the turn-off command itself
            off_ticks_ff <= (nxt_state == S_OFFDLY || nxt_state == S_FALL) ?
                (tick ? off_ticks_ff + 18'h00001 : off_ticks_ff) :
                18'h00000;
            // Ramp time: steps to zero times ticks per step
            fall_ticks_ff <= {8'h00, vref_ff[11:2]} *
                {10'h000, step_ticks(fall_code_ff, 1'b0)};
            ramping_ff <= (nxt_state == S_RISE || nxt_state == S_FALL);
            steady_ff <= (nxt_state == S_ON);
            if (nxt_state == S_OFF) begin
                vref_ff <= 12'h000;
                switches_on_ff <= 1'b0;
            end else if (state_ff == S_RISE && step) begin
                vref_ff <= (target - vref_ff > `ORS_STEP_LSB) ?
                    vref_ff + `ORS_STEP_LSB : target;
                // Held off while a prebiased output sits above the ramp
                switches_on_ff <= switches_on_ff |
                    (vref_ff >= prebias_level);
            end else if (state_ff == S_FALL && step) begin
                vref_ff <= (vref_ff > `ORS_STEP_LSB) ?
                    vref_ff - `ORS_STEP_LSB : 12'h000;
            end else if (state_ff == S_ON) begin
                vref_ff <= target;
                switches_on_ff <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* hw/ors_step_timer.v */
/*
 Step timer: counts master-clock ticks and fires once per ramp step.
 Assumes tick is a one-cycle enable in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ors_step_timer (
    input wire clock,
    input wire rst,
    input wire tick,
    input wire run,
    input wire [7:0] ticks_per_step,
    output reg step_ff
);
    reg [7:0] cnt_ff;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_ff <= 8'h00;
            step_ff <= 1'b0;
        end else begin
            step_ff <= 1'b0;
            if (!run) begin
                cnt_ff <= 8'h00;
            end else if (tick) begin
                if (cnt_ff + 8'h01 >= ticks_per_step) begin
                    cnt_ff <= 8'h00;
                    step_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* test/ors_host_model.sv */
/* Power manager model: free-running master clock and byte port tasks.
 Assumes the bench calls the tasks only after reset release. */
`timescale 1ns/1ps
`default_nettype none
module ors_host_model (
    input wire logic clock,
    input wire logic [7:0] reg_rdata_ff,
    output var logic master_clk_pin,
    output var logic reg_wr,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata
);
    logic [1:0] div_ff = 2'h0;
    initial begin
        master_clk_pin = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Scaled master clock: a tick every eight cycles keeps runs short
    always @(posedge clock) begin
        div_ff <= div_ff + 2'h1;
        if (div_ff == 2'h3) begin
            master_clk_pin <= !master_clk_pin;
        end
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1 d = reg_rdata_ff;
    endtask
endmodule
`default_nettype wire

/* test/ors_seq_chk.sv */
/* Port checker for the output ramp sequencer.
 Bound from the bench top; sees only the top-level ports. */
`timescale 1ns/1ps
`default_nettype none
module ors_seq_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic master_clk_pin,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic turn_on,
    input wire logic [11:0] setpoint,
    input wire logic [11:0] prebias_level,
    input wire logic [11:0] load_current,
    input wire logic [11:0] vref_ff,
    input wire logic switches_on_ff,
    input wire logic ramping_ff,
    input wire logic steady_ff
);
    logic fall_en_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Mirror of the falling ramp enable, taken from the byte port
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fall_en_ff <= 1'b1;
        end else if (reg_wr && reg_addr == 8'h03) begin
            fall_en_ff <= reg_wdata[3];
        end
    end
    AST_STEP_UP: assert property (vref_ff > $past(vref_ff)
        |-> vref_ff == $past(vref_ff) + 12'h004) else $error("bad up step");
    AST_STEP_DN: assert property (
        switches_on_ff && vref_ff < $past(vref_ff)
        |-> vref_ff == $past(vref_ff) - 12'h004) else $error("bad down step");
    AST_UP_LIMIT: assert property (
        vref_ff > $past(vref_ff) |-> vref_ff <= setpoint && $past(turn_on))
        else $error("rise without command or past setpoint");
    AST_DN_CAUSE: assert property (
        switches_on_ff && vref_ff < $past(vref_ff)
        |-> fall_en_ff && !$past(turn_on)) else $error("unexpected fall");
    AST_PREBIAS: assert property ($rose(switches_on_ff)
        |-> vref_ff >= prebias_level) else $error("switched below prebias");
    AST_ZERO_OFF: assert property (
        $fell(switches_on_ff) && fall_en_ff |-> vref_ff == 12'h000)
        else $error("ramp-down ended above zero");
    // Ticks are eight cycles apart, so a step under four cycles after the last bypassed the divider
    AST_STEP_GAP: assert property (vref_ff > $past(vref_ff)
        |-> $past(vref_ff) == $past(vref_ff, 4)) else $error("step too soon");
    AST_READBACK: assert property (reg_wr && reg_addr == 8'h05
        ##1 !reg_wr && reg_addr == 8'h05
        |=> reg_rdata_ff == $past(reg_wdata, 2)) else $error("bad readback");
    AST_RISE_VALID: assert property (
        $past(reg_addr) == 8'h03 && $past(reg_addr, 2) == 8'h03
        |-> reg_rdata_ff[6:4] inside {[3'h1:3'h6]}) else $error("bad rise code");
    cover property ($rose(steady_ff));
    cover property ($fell(switches_on_ff) && fall_en_ff);
    cover property ($fell(switches_on_ff) && !fall_en_ff);
endmodule
`default_nettype wire

/* test/test_output_ramp_sequencer.sv */
/* Self-checking bench for the output ramp sequencer.
 Host model drives the byte port and the master clock. */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %h want %h", $time, g, e); end end
module test_output_ramp_sequencer;
    logic clock, rst, turn_on, mclk, reg_wr, sw_on, ramping, steady;
    logic [7:0] reg_addr, reg_wdata, rdata, rd;
    logic [11:0] setpoint, prebias, load, vref;
    int miscompares, compares, n;
    ors_host_model host_u (.clock(clock), .reg_rdata_ff(rdata),
        .master_clk_pin(mclk), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    ors_sequencer dut_u (.clock(clock), .rst(rst), .master_clk_pin(mclk),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(rdata), .turn_on(turn_on), .setpoint(setpoint),
        .prebias_level(prebias), .load_current(load), .vref_ff(vref),
        .switches_on_ff(sw_on), .ramping_ff(ramping), .steady_ff(steady));
    initial begin
        clock = 1'b0;
        forever #10 clock = !clock;
    end
    task automatic end_of_test;
        $display("Mismatches %0d, compares %0d", miscompares, compares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Sampled on the falling edge, away from input changes
    task automatic wait_lvl(ref logic s, input logic lvl);
        n = 0;
        while (s !== lvl && n < 3000) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic t_regs;
        host_u.read_reg(8'h05, rd);
        `CHECK(rd, 8'h00)
        host_u.read_reg(8'h03, rd);
        `CHECK(rd, 8'h1C)
        host_u.read_reg(8'h21, rd);
        `CHECK(rd, 8'h00)
        host_u.write_reg(8'h03, 8'h6D);
        host_u.read_reg(8'h03, rd);
        `CHECK(rd, 8'h6D)
        host_u.write_reg(8'h03, 8'h7F);
        host_u.read_reg(8'h03, rd);
        `CHECK(rd, 8'h6D)
    endtask
    task automatic t_turn_on;
        host_u.write_reg(8'h05, 8'h01);
        host_u.write_reg(8'h07, 8'h02);
        @(posedge clock);
        turn_on <= 1'b1;
        repeat (700) @(negedge clock);
        `CHECK(vref, 12'h000)
        wait_lvl(steady, 1'b1);
        `CHECK(vref, 12'h028)
        `CHECK(sw_on, 1'b1)
    endtask
    task automatic t_fall;
        host_u.write_reg(8'h06, 8'h01);
        @(posedge clock);
        turn_on <= 1'b0;
        repeat (600) @(negedge clock);
        `CHECK(vref, 12'h028)
        wait_lvl(sw_on, 1'b0);
        `CHECK(n > 179 && n < 231, 1'b1)
        `CHECK(vref, 12'h000)
    endtask
    task automatic t_no_ramp;
        host_u.write_reg(8'h03, 8'h65);
        @(posedge clock);
        turn_on <= 1'b1;
        wait_lvl(steady, 1'b1);
        @(posedge clock);
        turn_on <= 1'b0;
        repeat (600) @(negedge clock);
        `CHECK(vref, 12'h028)
        wait_lvl(sw_on, 1'b0);
        `CHECK(n > 179 && n < 231, 1'b1)
    endtask
    initial begin
        rst = 1'b1;
        turn_on = 1'b0;
        setpoint = 12'h030;
        prebias = 12'h014;
        load = 12'h020;
        miscompares = 0;
        compares = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_turn_on();
        t_fall();
        t_no_ramp();
        end_of_test();
    end
    // Scenarios take about 3400 cycles; the limit of 20000 lies well above this
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_of_test();
    end
endmodule
bind ors_sequencer ors_seq_chk chk_u (.clock(clock), .rst(rst),
    .master_clk_pin(master_clk_pin), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .turn_on(turn_on),
    .setpoint(setpoint), .prebias_level(prebias_level),
    .load_current(load_current), .vref_ff(vref_ff),
    .switches_on_ff(switches_on_ff), .ramping_ff(ramping_ff),
    .steady_ff(steady_ff));
`default_nettype wire
